/* File: test/apb_host.sv */
// Configuration host model: an APB master issuing one transfer per call.
// Assumes the slave raises pready within the bench's watchdog span.
`timescale 1ns/100ps
module apb_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // --------------------------------------------------------------------------
  // Idle bus at time zero
  // --------------------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // Setup, then access held until pready; released address and data lines show inverted junk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host

/* File: test/cap_regs_assertions.sv */
// Concurrent checks on the capability register bank, seen from its top ports.
// Assumes one clock pclk and the asynchronous active-low reset presetn.
`timescale 1ns/100ps
module cap_regs_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic port_is_upstream,
  input wire logic l11_sw_enable,
  input wire logic l11_hw_enable,
  input wire logic [31:0] latency_limit
);
  // --------------------------------------------------------------------------
  // Transfer qualifiers
  // --------------------------------------------------------------------------
  wire logic acc = psel && penable && pready; // Completing transfer
  wire logic rd = acc && !pwrite; // Read data valid now
  wire logic wr = acc && pwrite; // Write lands at this edge
  wire logic [9:0] wa = paddr[11:2]; // Word index, byte lanes ignored
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  AST_LAT_WR: assert property (wr && wa == 10'h08D && port_is_upstream && pstrb == 4'hF |=>
    latency_limit == {3'h0, $past(pwdata[28:16]), 3'h0, $past(pwdata[12:0])}) else $error("latency write lost");
  AST_LAT_RSV: assert property (latency_limit[31:29] == 3'h0 && latency_limit[15:13] == 3'h0)
    else $error("latency reserved bits set");
  AST_LAT_DOWN: assert property (!port_is_upstream |-> latency_limit == 32'h0)
    else $error("latency word alive on downstream role");
  AST_SS_HDR: assert property (rd && wa == 10'h090 |->
    prdata == {(port_is_upstream ? 12'h260 : 12'h250), 4'h1, 16'h001E}) else $error("substates header wrong");
  AST_DPC_HDR: assert property (rd && wa == 10'h094 |->
    prdata == (port_is_upstream ? 32'h0 : 32'h0001001D)) else $error("containment header wrong");
  AST_DPC_CAP: assert property (rd && wa == 10'h095 && !port_is_upstream |-> prdata[15:0] == 16'h0001)
    else $error("containment vector wrong");
  AST_CAP_RSV: assert property (rd && wa == 10'h091 |-> (prdata & 32'hFFFFFFE5) == 32'h0)
    else $error("capability reserved bits set");
  AST_CTRL_WR: assert property (wr && wa == 10'h092 && pstrb[0] |=>
    l11_sw_enable == $past(pwdata[1]) && l11_hw_enable == $past(pwdata[3])) else $error("enable write lost");
  AST_CTRL_HOLD: assert property (!(wr && wa == 10'h092) |=> $stable({l11_sw_enable, l11_hw_enable}))
    else $error("enable changed without a write");
  AST_CTRL_RD: assert property (rd && wa == 10'h092 |->
    prdata == {28'h0, l11_hw_enable, 1'b0, l11_sw_enable, 1'b0}) else $error("control readback wrong");
  AST_ERR: assert property (pready |-> pslverr == (wa < 10'h08D || wa > 10'h095))
    else $error("error response wrong");
  // Main scenarios reached
  cover property (wr && wa == 10'h08D);
  cover property (rd && wa == 10'h094 && !port_is_upstream);
  cover property (pready && pslverr);
endmodule : cap_regs_assertions

bind l1_substates_dpc_cap_regs cap_regs_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .port_is_upstream(port_is_upstream), .l11_sw_enable(l11_sw_enable),
  .l11_hw_enable(l11_hw_enable), .latency_limit(latency_limit));

/* File: test/l1_substates_dpc_cap_regs_tb.sv */
// Self-checking bench of the capability register bank over APB.
// Assumes the host model apb_host and the bound checker.
`timescale 1ns/100ps
module l1_substates_dpc_cap_regs_tb;
  logic pclk = 1'b0, presetn = 1'b0, strap = 1'b1, ee_v = 1'b0, sm_v = 1'b0, sm_hw = 1'b0;
  logic [2:0] ee_caps = 3'h0;
  logic psel, penable, pwrite, pready, pslverr, up, sw_en, hw_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lat;
  logic [3:0] pstrb;
  int n_errors = 0, checks_done = 0;
  always #10 pclk = ~pclk; // 50 MHz
  apb_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  l1_substates_dpc_cap_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_upstream_pin(strap), .eeprom_load_valid(ee_v), .eeprom_caps(ee_caps),
    .smbus_load_valid(sm_v), .smbus_l11_hw_cap(sm_hw), .port_is_upstream(up), .l11_sw_enable(sw_en),
    .l11_hw_enable(hw_en), .latency_limit(lat));
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    i_host.xfer(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    i_host.xfer(1'b1, a, d, s, r, e);
    // Registered outputs update at the completing edge; look once settled
    @(negedge pclk);
  endtask : wr
  // Strap is settled before release; requests start after the fourth edge
  task automatic do_reset(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= s;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset
  task automatic pulse_ee(input logic [2:0] c);
    @(posedge pclk);
    ee_v <= 1'b1;
    ee_caps <= c;
    @(posedge pclk);
    ee_v <= 1'b0;
  endtask : pulse_ee
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_vals;
    chk({31'h0, up}, 32'h1);
    rd(12'h234, 32'h0, 1'b0);
    rd(12'h244, 32'h12, 1'b0);
    rd(12'h248, 32'h0, 1'b0);
    rd(12'h24C, 32'h0, 1'b0);
  endtask : t_reset_vals
  // Byte strobes split the two halves; reserved bits never stick
  task automatic t_latency;
    wr(12'h234, 32'hFFFFFFFF, 4'hF);
    rd(12'h234, 32'h1FFF1FFF, 1'b0);
    wr(12'h234, 32'h0000ABCD, 4'h3);
    rd(12'h234, 32'h1FFF0BCD, 1'b0);
    wr(12'h234, 32'h00000000, 4'hC);
    chk(lat, 32'h00000BCD);
  endtask : t_latency
  task automatic t_headers(input logic u);
    wr(12'h240, 32'hFFFFFFFF, 4'hF);
    rd(12'h240, u ? 32'h2601001E : 32'h2501001E, 1'b0);
    rd(12'h250, u ? 32'h0 : 32'h0001001D, 1'b0);
    wr(12'h254, 32'hFFFFFFFF, 4'hF);
    rd(12'h254, u ? 32'h0 : 32'h1, 1'b0);
  endtask : t_headers
  task automatic t_ctrl;
    wr(12'h248, 32'hFFFFFFFF, 4'hF);
    rd(12'h248, 32'h0000000A, 1'b0);
    wr(12'h248, 32'h00000002, 4'h1);
    chk({30'h0, hw_en, sw_en}, 32'h1);
  endtask : t_ctrl
  // Loader and SMBus override the defaults; software cannot
  task automatic t_preload;
    pulse_ee(3'b010);
    rd(12'h244, 32'h08, 1'b0);
    @(posedge pclk);
    sm_v <= 1'b1;
    sm_hw <= 1'b0;
    @(posedge pclk);
    sm_v <= 1'b0;
    wr(12'h244, 32'hFFFFFFFF, 4'hF);
    rd(12'h244, 32'h00, 1'b0);
    pulse_ee(3'b111);
    rd(12'h244, 32'h1A, 1'b0);
    // Both loads in one cycle: SMBus keeps the hardware L1.1 bit
    @(posedge pclk);
    ee_v <= 1'b1;
    ee_caps <= 3'b111;
    sm_v <= 1'b1;
    sm_hw <= 1'b0;
    @(posedge pclk);
    ee_v <= 1'b0;
    sm_v <= 1'b0;
    rd(12'h244, 32'h12, 1'b0);
  endtask : t_preload
  task automatic t_unmapped;
    rd(12'h300, 32'h0, 1'b1);
    rd(12'h238, 32'h0, 1'b0);
  endtask : t_unmapped
  task automatic t_down;
    do_reset(1'b0);
    chk({31'h0, up}, 32'h0);
    wr(12'h234, 32'hFFFFFFFF, 4'hF);
    rd(12'h234, 32'h0, 1'b0);
    t_headers(1'b0);
    rd(12'h254, 32'h1, 1'b0);
  endtask : t_down
  // --------------------------------------------------------------------------
  // Verdict and run control
  // --------------------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #200us;
    n_errors++;
    close_out();
  end
  initial begin
    do_reset(1'b1);
    t_reset_vals();
    t_latency();
    t_headers(1'b1);
    t_ctrl();
    t_preload();
    t_unmapped();
    t_down();
    close_out();
  end
endmodule : l1_substates_dpc_cap_regs_tb

/* File: verilog/cap_preload.sv */
// Holds the capability bits that EEPROM autoload or SMBus/I2C may overwrite.
// Assumes load strobes are one-cycle pulses from logic on pclk.
`timescale 1ns/100ps
`include "cap_regs_cfg.svh"
module cap_preload import cap_regs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic eeprom_load_valid,
  input wire cap_bits_s eeprom_caps,
  input wire logic smbus_load_valid,
  input wire logic smbus_l11_hw_cap,
  cap_preload_if.loader cap
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    cap_bits_s caps; // Current capability defaults
  } loader_s;

  loader_s cur_ff; // Registered state
  loader_s nxt_cur; // Next state

  // Each load source overwrites only the bits it is allowed to touch
  always_comb begin
    nxt_cur = cur_ff;
    // Autoload may replace all three bits
    if (eeprom_load_valid) begin
      nxt_cur.caps = eeprom_caps;
    end
    // SMBus applied last so it wins a same-cycle collision on its bit
    if (smbus_load_valid) begin
      nxt_cur.caps.l11_hw_cap = smbus_l11_hw_cap;
    end
  end

  // Register the state; defaults advertise L1.1 software and L1 substates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff.caps.l11_sw_cap <= `RST_L11_SW_CAP;
      cur_ff.caps.l11_hw_cap <= `RST_L11_HW_CAP;
      cur_ff.caps.l1ss_cap <= `RST_L1SS_CAP;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cap.caps = cur_ff.caps;

endmodule : cap_preload

/* File: verilog/cap_preload_if.sv */
// Carries preloaded capability bits from the loader to the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cap_preload_if;
  import cap_regs_pkg::*;
  cap_bits_s caps; // Current capability bits

  modport loader (output caps);
  modport bank (input caps);
endinterface : cap_preload_if

/* File: verilog/cap_regs_cfg.svh */
// Constants of the latency-limit, L1 substates and containment register bank.
// Assumes byte addressing inside a 4 KB extended configuration space.
`ifndef CAP_REGS_CFG_SVH
`define CAP_REGS_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_LATENCY_LIMIT 12'h234
`define OFF_SS_HEADER 12'h240
`define OFF_SS_CAPS 12'h244
`define OFF_SS_CTRL1 12'h248
`define OFF_SS_CTRL2 12'h24C
`define OFF_DPC_HEADER 12'h250
`define OFF_DPC_CAPS 12'h254

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POS_SNOOP_VAL 0
`define POS_SNOOP_SCL 10
`define POS_NOSNOOP_VAL 16
`define POS_NOSNOOP_SCL 26
`define POS_L11_SW 1
`define POS_L11_HW 3
`define POS_L1SS 4
`define POS_HDR_VER 16
`define POS_HDR_NEXT 20

// ----------------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------------
`define SS_CAP_ID 16'h001E
`define DPC_CAP_ID 16'h001D
`define CAP_VERSION 4'h1
`define SS_NEXT_UP 12'h260
`define SS_NEXT_DOWN 12'h250
`define DPC_NEXT 12'h000
`define DPC_MSG_NUM 5'h01
`define RST_LAT_VAL 10'h000
`define RST_LAT_SCL 3'h0
`define RST_L11_SW_CAP 1'h1
`define RST_L11_HW_CAP 1'h0
`define RST_L1SS_CAP 1'h1
`define RST_CTRL2 32'h00000000

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
// Edges after reset release before the synchronised role pin is trusted
`define STRAP_FILL 2'h2

`endif

/* File: verilog/cap_regs_pkg.sv */
// Types shared by the capability register bank and its preload module.
// Assumes cap_regs_cfg.svh supplies every number.
package cap_regs_pkg;

  // --------------------------------------------------------------------------
  // Register selection after address decode
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_LATENCY,
    SEL_SS_HEADER,
    SEL_SS_CAPS,
    SEL_SS_CTRL1,
    SEL_SS_CTRL2,
    SEL_DPC_HEADER,
    SEL_DPC_CAPS,
    SEL_NONE
  } reg_sel_e;

  // Capability defaults as preloaded
  typedef struct packed {
    logic l11_sw_cap; // Software-directed L1.1 supported
    logic l11_hw_cap; // Hardware-autonomous L1.1 supported
    logic l1ss_cap; // L1 substates supported
  } cap_bits_s;

endpackage : cap_regs_pkg

/* File: verilog/l1_substates_dpc_cap_regs.sv */
// Latency-limit upper/lower halves, L1 substates capability and the head of
// the containment capability, reached over APB.
// Assumes an APB master on pclk and a port-role strap pin that is static.
//
// Functional notes
// - Upstream no-snoop latency value, RW, reset zero
// - Upstream no-snoop scale RW bits 28:26, 31:29 reserved
// - No-snoop fields upstream only, share word 234h
// - Substates header: ID 001Eh, version 1, read-only
// - Next pointer 260h upstream, 250h downstream
// - Software L1.1 capability reads one, autoload overridable
// - Hardware L1.1 capability zero, SMBus/autoload overridable
// - L1 substates capability one, autoload overridable
// - Control bit 1: software L1.1 enable, RW
// - Control bit 3: hardware L1.1 enable, RW
// - Containment structure downstream only, header at 250h
// - Containment header: ID 001Dh, version 1, next 000h
// - Containment capability reports MSI vector 00001b
// - Snoop value bits 9:0, scale bits 12:10
`timescale 1ns/100ps
`include "cap_regs_cfg.svh"
module l1_substates_dpc_cap_regs import cap_regs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic port_upstream_pin,
  input wire logic eeprom_load_valid,
  input wire logic [2:0] eeprom_caps,
  input wire logic smbus_load_valid,
  input wire logic smbus_l11_hw_cap,
  output logic port_is_upstream,
  output logic l11_sw_enable,
  output logic l11_hw_enable,
  output logic [31:0] latency_limit
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic strap_meta; // First synchroniser stage of the role pin
    logic strap_sync; // Second synchroniser stage
    logic [1:0] strap_fill; // Edges since release, stops at the fill count
    logic strap_done; // Role has been captured
    logic upstream; // Captured role: 1 upstream, 0 downstream
    logic ready; // APB access-phase ready
    logic slverr; // APB error answer
    logic [31:0] rdata; // APB read data
    logic [9:0] snoop_val; // Snoop latency value
    logic [2:0] snoop_scl; // Snoop latency scale
    logic [9:0] nosnoop_val; // No-snoop latency value
    logic [2:0] nosnoop_scl; // No-snoop latency scale
    logic l11_sw_en; // Software-directed L1.1 enable
    logic l11_hw_en; // Hardware-autonomous L1.1 enable
  } bank_s;

  bank_s cur_ff; // Registered state
  bank_s nxt_cur; // Next state

  cap_preload_if preload (); // Capability bits from the loader

  // --------------------------------------------------------------------------
  // Capability preload
  // --------------------------------------------------------------------------
  cap_preload u_preload (
    .pclk (pclk),
    .presetn (presetn),
    .eeprom_load_valid (eeprom_load_valid),
    .eeprom_caps (cap_bits_s'(eeprom_caps)),
    .smbus_load_valid (smbus_load_valid),
    .smbus_l11_hw_cap (smbus_l11_hw_cap),
    .cap (preload.loader)
  );

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------

  // Address to register; structures absent for this role decode as none
  function automatic reg_sel_e decode(input logic [11:0] addr, input logic up);
    reg_sel_e sel;
    sel = SEL_NONE;
    unique case ({addr[11:2], 2'b00})
      `OFF_LATENCY_LIMIT: sel = up ? SEL_LATENCY : SEL_NONE;
      `OFF_SS_HEADER: sel = SEL_SS_HEADER;
      `OFF_SS_CAPS: sel = SEL_SS_CAPS;
      `OFF_SS_CTRL1: sel = SEL_SS_CTRL1;
      `OFF_SS_CTRL2: sel = SEL_SS_CTRL2;
      `OFF_DPC_HEADER: sel = up ? SEL_NONE : SEL_DPC_HEADER;
      `OFF_DPC_CAPS: sel = up ? SEL_NONE : SEL_DPC_CAPS;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // Extended capability header word
  function automatic logic [31:0] cap_header(input logic [15:0] id, input logic [11:0] next);
    logic [31:0] word;
    word = 32'h00000000;
    word[15:0] = id;
    word[`POS_HDR_VER +: 4] = `CAP_VERSION;
    word[`POS_HDR_NEXT +: 12] = next;
    return word;
  endfunction : cap_header

  // Latency limit word as stored; reserved bits stay zero
  function automatic logic [31:0] latency_word(input bank_s s);
    logic [31:0] word;
    word = 32'h00000000;
    word[`POS_SNOOP_VAL +: 10] = s.snoop_val;
    word[`POS_SNOOP_SCL +: 3] = s.snoop_scl;
    word[`POS_NOSNOOP_VAL +: 10] = s.nosnoop_val;
    word[`POS_NOSNOOP_SCL +: 3] = s.nosnoop_scl;
    return word;
  endfunction : latency_word

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------

  // Strap capture, APB answer and register writes
  always_comb begin
    reg_sel_e sel;
    logic [31:0] rd;
    logic [31:0] wmask;
    logic [31:0] merged;
    nxt_cur = cur_ff;
    sel = decode(paddr, cur_ff.upstream);
    rd = 32'h00000000;
    // Byte strobes widened to a bit mask
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    merged = (latency_word(cur_ff) & ~wmask) | (pwdata & wmask);

    // Role pin: only the second stage is read by logic
    nxt_cur.strap_meta = port_upstream_pin;
    nxt_cur.strap_sync = cur_ff.strap_meta;
    // Take the role once, only after both stages hold the pin; an earlier
    // capture would latch the reset value of the second stage instead
    if (cur_ff.strap_fill != `STRAP_FILL) begin
      nxt_cur.strap_fill = cur_ff.strap_fill + 2'h1;
    end else if (!cur_ff.strap_done) begin
      nxt_cur.upstream = cur_ff.strap_sync;
      nxt_cur.strap_done = 1'b1;
    end

    // Read data per register
    unique case (sel)
      SEL_LATENCY: rd = latency_word(cur_ff);
      SEL_SS_HEADER: rd = cap_header(`SS_CAP_ID, cur_ff.upstream ? `SS_NEXT_UP : `SS_NEXT_DOWN);
      SEL_SS_CAPS: begin
        rd[`POS_L11_SW] = preload.caps.l11_sw_cap;
        rd[`POS_L11_HW] = preload.caps.l11_hw_cap;
        rd[`POS_L1SS] = preload.caps.l1ss_cap;
      end
      SEL_SS_CTRL1: begin
        rd[`POS_L11_SW] = cur_ff.l11_sw_en;
        rd[`POS_L11_HW] = cur_ff.l11_hw_en;
      end
      SEL_SS_CTRL2: rd = `RST_CTRL2;
      SEL_DPC_HEADER: rd = cap_header(`DPC_CAP_ID, `DPC_NEXT);
      SEL_DPC_CAPS: rd[4:0] = `DPC_MSG_NUM;
      SEL_NONE: rd = 32'h00000000;
    endcase

    // Answer one cycle after setup: ready rises in the first access cycle
    nxt_cur.ready = psel && !penable;
    if (psel && !penable) begin
      nxt_cur.rdata = pwrite ? 32'h00000000 : rd;
      // Only addresses outside 234h..257h err; holes inside that span and absent structures read zero
      nxt_cur.slverr = (paddr < `OFF_LATENCY_LIMIT) || (paddr > (`OFF_DPC_CAPS + 12'h003));
    end else if (!psel) begin
      nxt_cur.rdata = 32'h00000000;
      nxt_cur.slverr = 1'b0;
    end

    // Write takes effect at the completing edge only
    if (psel && penable && cur_ff.ready && pwrite && !cur_ff.slverr) begin
      unique case (sel)
        SEL_LATENCY: begin
          nxt_cur.snoop_val = merged[`POS_SNOOP_VAL +: 10];
          nxt_cur.snoop_scl = merged[`POS_SNOOP_SCL +: 3];
          nxt_cur.nosnoop_val = merged[`POS_NOSNOOP_VAL +: 10];
          nxt_cur.nosnoop_scl = merged[`POS_NOSNOOP_SCL +: 3];
        end
        SEL_SS_CTRL1: begin
          if (pstrb[0]) begin
            nxt_cur.l11_sw_en = pwdata[`POS_L11_SW];
            nxt_cur.l11_hw_en = pwdata[`POS_L11_HW];
          end
        end
        // Read-only, reserved and absent words ignore writes
        SEL_SS_HEADER, SEL_SS_CAPS, SEL_SS_CTRL2, SEL_DPC_HEADER, SEL_DPC_CAPS, SEL_NONE: begin
          nxt_cur.l11_sw_en = cur_ff.l11_sw_en;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // Everything resets to constants; the role is taken after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff.strap_meta <= 1'b0;
      cur_ff.strap_sync <= 1'b0;
      cur_ff.strap_fill <= 2'h0;
      cur_ff.strap_done <= 1'b0;
      cur_ff.upstream <= 1'b0;
      cur_ff.ready <= 1'b0;
      cur_ff.slverr <= 1'b0;
      cur_ff.rdata <= 32'h00000000;
      cur_ff.snoop_val <= `RST_LAT_VAL;
      cur_ff.snoop_scl <= `RST_LAT_SCL;
      cur_ff.nosnoop_val <= `RST_LAT_VAL;
      cur_ff.nosnoop_scl <= `RST_LAT_SCL;
      cur_ff.l11_sw_en <= 1'b0;
      cur_ff.l11_hw_en <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // --------------------------------------------------------------------------
  assign pready = cur_ff.ready;
  assign prdata = cur_ff.rdata;
  assign pslverr = cur_ff.slverr;
  assign port_is_upstream = cur_ff.upstream;
  assign l11_sw_enable = cur_ff.l11_sw_en;
  assign l11_hw_enable = cur_ff.l11_hw_en;
  // Downstream ports hold the word at zero since it is never writable there
  assign latency_limit = {3'b000, cur_ff.nosnoop_scl, cur_ff.nosnoop_val, 3'b000, cur_ff.snoop_scl, cur_ff.snoop_val};

endmodule : l1_substates_dpc_cap_regs
